// ### core/ssi_top.sv
// status indicator: LED/beeper patterns, intrusion latch, wake qualifier,
// interface disables, hood solenoid drive and fan requests
// assumes AXI4-Lite master on aclk; pin inputs synchronous to aclk
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ssi_params.svh"

module ssi_top #(
  parameter int ADDR_W       = 8,
  parameter int HALF_SEC_CYC = `SSI_HALF_SEC_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              rtc_rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              cover_n,
  input  wire logic [7:0]        wake_src,
  input  wire logic              cpu_hot,
  input  wire logic              psu_hot,
  output logic                   led_green,
  output logic                   led_red,
  output logic                   beep,
  output logic                   wake_req,
  output logic                   serial_dis,
  output logic                   parallel_dis,
  output logic                   usb_dis,
  output logic                   diskette_dis,
  output logic                   media_wr_en,
  output logic                   media_boot_en,
  output logic                   hood_lock,
  output logic                   hood_unlock,
  output logic                   fan_on,
  output logic                   fan_high,
  output logic                   irq
);

  generate
    if (ADDR_W < 8 || HALF_SEC_CYC < 2) begin : g_bad
      $error("ssi_top: ADDR_W must be >= 8 and HALF_SEC_CYC >= 2");
    end
  endgenerate

  // ************
  // helpers
  // ************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic is_blink_state(input logic [2:0] ps);
    is_blink_state = (ps == ssi_pkg::SSI_S1) || (ps == ssi_pkg::SSI_S3);
  endfunction

  function automatic logic is_off_state(input logic [2:0] ps);
    is_off_state = (ps == ssi_pkg::SSI_S4) || (ps == ssi_pkg::SSI_S5);
  endfunction

  // ************
  // AXI4-Lite slave
  // ************
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic              wr_go;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_data;
  logic [7:0]        waddr;
  logic [7:0]        raddr;

  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign waddr = aw_addr_reg[7:0];
  assign raddr = s_axi_araddr[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSI_RESP_OKAY;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SSI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_hit ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ************
  // software registers
  // ************
  logic [2:0]  pstate_reg;
  logic        boot_done_reg;
  logic [5:0]  security_reg;
  logic [1:0]  hood_reg;
  logic [2:1]  status_reg;
  logic [2:0]  status_all;
  logic [2:0]  mask_reg;
  logic [7:0]  wake_snap_reg;
  logic        intr_latch_reg;
  logic [3:0]  fault_code_reg;
  logic        fault_act_reg;
  logic [2:0]  burst_cnt_reg;
  logic [15:0] ctrl_next;
  logic [15:0] w16;
  logic        fault_start;
  logic        wake_hit;

  assign ctrl_next = merge16({12'h000, boot_done_reg, pstate_reg}, w_data_reg, w_strb_reg);
  assign w16       = merge16(16'h0000, w_data_reg, w_strb_reg);
  assign fault_start = wr_go && waddr == `SSI_OFF_FAULT && w_strb_reg[0] && !fault_act_reg
                       && w_data_reg[3:0] >= `SSI_CODE_MIN && w_data_reg[3:0] <= `SSI_CODE_MAX;

  always_comb begin
    wr_hit = 1'b1;
    case (waddr)
      `SSI_OFF_CTRL, `SSI_OFF_FAULT, `SSI_OFF_SECURITY, `SSI_OFF_HOOD,
      `SSI_OFF_STATUS, `SSI_OFF_MASK, `SSI_OFF_WAKE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (raddr)
      `SSI_OFF_CTRL:     rd_data = {28'h0, boot_done_reg, pstate_reg};
      `SSI_OFF_FAULT:    rd_data = {21'h0, burst_cnt_reg, 3'h0, fault_act_reg, fault_code_reg};
      `SSI_OFF_SECURITY: rd_data = {26'h0, security_reg};
      `SSI_OFF_HOOD:     rd_data = {30'h0, hood_reg};
      `SSI_OFF_STATUS:   rd_data = {22'h0, fan_high, fan_on, 5'h0, status_all};
      `SSI_OFF_MASK:     rd_data = {29'h0, mask_reg};
      `SSI_OFF_WAKE:     rd_data = {24'h0, wake_snap_reg};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pstate_reg    <= ssi_pkg::SSI_S0;
      boot_done_reg <= 1'b0;
      security_reg  <= `SSI_SEC_RESET;
      hood_reg      <= 2'h0;
      mask_reg      <= 3'h0;
    end else if (wr_go) begin
      case (waddr)
        `SSI_OFF_CTRL: begin
          pstate_reg    <= ctrl_next[2:0];
          boot_done_reg <= ctrl_next[`SSI_CTRL_BOOT];
        end
        `SSI_OFF_SECURITY: security_reg <= w16[5:0];
        `SSI_OFF_HOOD:     hood_reg     <= w16[1:0];
        `SSI_OFF_MASK:     mask_reg     <= w16[2:0];
        default: ;
      endcase
    end
  end

  // ************
  // intrusion latch and sticky status
  // ************
  // battery domain reset only; a system reset must not forget a cover removal
  always_ff @(posedge aclk) begin
    if (!rtc_rstn) begin
      intr_latch_reg <= 1'b0;
    end else if (!cover_n) begin
      intr_latch_reg <= 1'b1;
    end else if (wr_go && waddr == `SSI_OFF_STATUS && w16[`SSI_ST_INTR] && boot_done_reg) begin
      intr_latch_reg <= 1'b0;
    end
  end

  always_comb begin
    wake_hit = |wake_src[7:5] && is_blink_state(pstate_reg);
    if (is_blink_state(pstate_reg) || is_off_state(pstate_reg)) begin
      wake_hit = wake_hit || |wake_src[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg[2:1] <= 2'h0;
      wake_snap_reg   <= 8'h00;
      wake_req        <= 1'b0;
    end else begin
      wake_req <= wake_hit;
      if (wake_hit) begin
        wake_snap_reg <= wake_src;
      end
      // set wins over a simultaneous write-one clear
      if (wake_hit) begin
        status_reg[`SSI_ST_WAKE] <= 1'b1;
      end else if (wr_go && waddr == `SSI_OFF_STATUS && w16[`SSI_ST_WAKE]) begin
        status_reg[`SSI_ST_WAKE] <= 1'b0;
      end
      if (fault_start) begin
        status_reg[`SSI_ST_FAULT] <= 1'b1;
      end else if (wr_go && waddr == `SSI_OFF_STATUS && w16[`SSI_ST_FAULT]) begin
        status_reg[`SSI_ST_FAULT] <= 1'b0;
      end
    end
  end

  // intrusion bit lives in the battery domain, so it is merged here, not stored twice
  assign status_all = {status_reg, intr_latch_reg};

  // ************
  // half-second time base and fault sequencer
  // ************
  logic [31:0]             half_cnt_reg;
  logic                    tick;
  logic [1:0]              gphase_reg;
  logic [3:0]              blink_cnt_reg;
  logic [2:0]              pause_cnt_reg;
  ssi_pkg::ssi_fstate_e    fst_reg;

  assign tick = (half_cnt_reg == 32'(HALF_SEC_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || fault_start || tick) begin
      half_cnt_reg <= 32'h0000_0000;
    end else begin
      half_cnt_reg <= half_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gphase_reg <= 2'h0;
    end else if (tick) begin
      gphase_reg <= gphase_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fst_reg        <= ssi_pkg::SSI_FS_IDLE;
      fault_act_reg  <= 1'b0;
      fault_code_reg <= 4'h0;
      blink_cnt_reg  <= 4'h0;
      pause_cnt_reg  <= 3'h0;
      burst_cnt_reg  <= 3'h0;
    end else begin
      case (fst_reg)
        ssi_pkg::SSI_FS_IDLE: begin
          if (fault_start) begin
            fault_act_reg  <= 1'b1;
            fault_code_reg <= w_data_reg[3:0];
            blink_cnt_reg  <= 4'h0;
            fst_reg        <= ssi_pkg::SSI_FS_ON;
          end
        end
        ssi_pkg::SSI_FS_ON: begin
          if (tick) begin
            fst_reg <= ssi_pkg::SSI_FS_OFF;
          end
        end
        ssi_pkg::SSI_FS_OFF: begin
          if (tick) begin
            if (blink_cnt_reg + 4'h1 == fault_code_reg) begin
              blink_cnt_reg <= 4'h0;
              pause_cnt_reg <= 3'h0;
              fst_reg       <= ssi_pkg::SSI_FS_PAUSE;
            end else begin
              blink_cnt_reg <= blink_cnt_reg + 4'h1;
              fst_reg       <= ssi_pkg::SSI_FS_ON;
            end
          end
        end
        ssi_pkg::SSI_FS_PAUSE: begin
          if (tick) begin
            if (pause_cnt_reg == `SSI_PAUSE_TICKS - 3'h1) begin
              fst_reg <= ssi_pkg::SSI_FS_ON;
              if (burst_cnt_reg != `SSI_BEEP_BURSTS) begin
                burst_cnt_reg <= burst_cnt_reg + 3'h1;
              end
            end else begin
              pause_cnt_reg <= pause_cnt_reg + 3'h1;
            end
          end
        end
        default: fst_reg <= ssi_pkg::SSI_FS_IDLE;
      endcase
    end
  end

  // ************
  // pin outputs
  // ************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
      beep      <= 1'b0;
    end else if (fault_act_reg) begin
      led_green <= 1'b0;
      led_red   <= (fst_reg == ssi_pkg::SSI_FS_ON);
      // piezo only; the chassis speaker is never driven from here
      beep      <= (fst_reg == ssi_pkg::SSI_FS_ON) && fault_code_reg <= `SSI_CODE_BEEP_MAX
                   && burst_cnt_reg != `SSI_BEEP_BURSTS;
    end else begin
      led_red   <= 1'b0;
      beep      <= 1'b0;
      if (is_blink_state(pstate_reg)) begin
        led_green <= !gphase_reg[1];
      end else begin
        led_green <= !is_off_state(pstate_reg);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_dis    <= 1'b0;
      parallel_dis  <= 1'b0;
      usb_dis       <= 1'b0;
      diskette_dis  <= 1'b0;
      media_wr_en   <= 1'b1;
      media_boot_en <= 1'b1;
      hood_lock     <= 1'b0;
      hood_unlock   <= 1'b0;
      fan_on        <= 1'b1;
      fan_high      <= 1'b0;
      irq           <= 1'b0;
    end else begin
      {media_boot_en, media_wr_en} <= security_reg[5:4];
      {diskette_dis, usb_dis, parallel_dis, serial_dis} <= security_reg[3:0];
      // both commands at once would fight the solenoid; drive neither
      hood_lock     <= hood_reg[0] && !hood_reg[1];
      hood_unlock   <= hood_reg[1] && !hood_reg[0];
      fan_high      <= cpu_hot;
      fan_on        <= (pstate_reg == ssi_pkg::SSI_S0) || cpu_hot || psu_hot;
      irq           <= |(status_all & mask_reg);
    end
  end

  // ************
  // assertions
  // ************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_last_off;
    fst_reg == ssi_pkg::SSI_FS_OFF && tick && blink_cnt_reg + 4'h1 == fault_code_reg;
  endsequence

  sequence s_pause_end;
    fst_reg == ssi_pkg::SSI_FS_PAUSE && tick && pause_cnt_reg == `SSI_PAUSE_TICKS - 3'h1;
  endsequence

  a_s0_green_on: assert property (!fault_act_reg && pstate_reg == ssi_pkg::SSI_S0
    |=> led_green && !led_red && !beep) else $error("working state not steady green");
  a_sleep_led_off: assert property (!fault_act_reg && is_off_state(pstate_reg)
    |=> !led_green) else $error("LED lit in soft-off");
  a_blink_quiet: assert property (!fault_act_reg && is_blink_state(pstate_reg)
    |=> !beep && !led_red) else $error("beep in suspend");
  a_burst_count: assert property (s_last_off |=> fst_reg == ssi_pkg::SSI_FS_PAUSE
    && !led_red) else $error("burst length wrong");
  a_blink_half_sec: assert property (fst_reg == ssi_pkg::SSI_FS_ON && tick
    |=> fst_reg == ssi_pkg::SSI_FS_OFF ##1 !led_red) else $error("blink not one hertz");
  a_pause_two_sec: assert property (s_pause_end |=> fst_reg == ssi_pkg::SSI_FS_ON
    ##1 led_red) else $error("pause not two seconds");
  a_code_ten_quiet: assert property (fault_act_reg && fault_code_reg == `SSI_CODE_MAX
    |=> !beep) else $error("beep for option card code");
  a_beep_limit: assert property (burst_cnt_reg == `SSI_BEEP_BURSTS
    |=> !beep [*2]) else $error("beep after five bursts");
  a_cover_latch: assert property (disable iff (!rtc_rstn) !cover_n
    |=> intr_latch_reg) else $error("intrusion not latched");
  a_intr_hold: assert property (disable iff (!rtc_rstn) intr_latch_reg && !boot_done_reg
    |=> intr_latch_reg) else $error("intrusion cleared before boot");
  a_wake_gate: assert property (is_off_state(pstate_reg) && wake_src[4:0] == 5'h00
    |=> !wake_req) else $error("suspend-only source woke soft-off");
  a_fan_stop: assert property (pstate_reg != ssi_pkg::SSI_S0 && !cpu_hot && !psu_hot
    |=> !fan_on) else $error("fan running in sleep");
  a_fault_sticky: assert property (fault_act_reg |=> fault_act_reg
    && !led_green) else $error("fault indication dropped");

endmodule

// ### core/ssi_params.svh
// register map, field positions, reset values and timing for the status indicator
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

// ************
// timing
// ************
`define SSI_CLK_MHZ        200
`define SSI_HALF_SEC_MS    500
`define SSI_HALF_SEC_CYC   (`SSI_HALF_SEC_MS * 1000 * `SSI_CLK_MHZ)
`define SSI_PAUSE_TICKS    3'h4
`define SSI_BEEP_BURSTS    3'h5

// ************
// fault codes
// ************
`define SSI_CODE_MIN       4'h2
`define SSI_CODE_BEEP_MAX  4'h9
`define SSI_CODE_MAX       4'hA

// ************
// register offsets
// ************
`define SSI_OFF_CTRL       8'h00
`define SSI_OFF_FAULT      8'h04
`define SSI_OFF_SECURITY   8'h08
`define SSI_OFF_HOOD       8'h0C
`define SSI_OFF_STATUS     8'h10
`define SSI_OFF_MASK       8'h14
`define SSI_OFF_WAKE       8'h18

// ************
// fields
// ************
`define SSI_CTRL_BOOT      3
`define SSI_ST_INTR        0
`define SSI_ST_WAKE        1
`define SSI_ST_FAULT       2
`define SSI_SEC_RESET      6'h30
`define SSI_RESP_OKAY      2'h0
`define SSI_RESP_SLVERR    2'h2

`endif

// ### core/ssi_pkg.sv
// types shared by the status indicator
// assumes ssi_params.svh is compiled alongside
package ssi_pkg;

  typedef enum logic [2:0] {
    SSI_S0 = 3'h0,
    SSI_S1 = 3'h1,
    SSI_S3 = 3'h3,
    SSI_S4 = 3'h4,
    SSI_S5 = 3'h5
  } ssi_pstate_e;

  typedef enum logic [1:0] {
    SSI_FS_IDLE  = 2'h0,
    SSI_FS_ON    = 2'h1,
    SSI_FS_OFF   = 2'h2,
    SSI_FS_PAUSE = 2'h3
  } ssi_fstate_e;

endpackage

// ### tb/ssi_panel_model.sv
// front panel model: led and piezo watcher, cover plunger, hood solenoid
// assumes the indicator outputs are registered on aclk
`timescale 1ns/1ps
module ssi_panel_model (
  input  wire logic aclk,
  input  wire logic cover_open,
  input  wire logic led_red,
  input  wire logic beep,
  input  wire logic hood_lock,
  input  wire logic hood_unlock,
  output logic      cover_n,
  output int        red_cnt,
  output int        beep_cnt,
  output logic      clash
);
  logic red_q;
  logic beep_q;
  initial begin
    red_cnt = 0;
    beep_cnt = 0;
    clash = 1'h0;
    red_q = 1'h0;
    beep_q = 1'h0;
  end
  // plunger grounds the line with the cover off; pull-up holds it high otherwise
  assign cover_n = cover_open ? 1'h0 : 1'h1;
  // ************
  // edge counters
  // ************
  always @(posedge aclk) begin
    red_q <= led_red;
    beep_q <= beep;
    if (led_red === 1'h1 && red_q !== 1'h1) red_cnt <= red_cnt + 1;
    if (beep === 1'h1 && beep_q !== 1'h1) beep_cnt <= beep_cnt + 1;
    // both coils at once would fight the bar
    if (hood_lock === 1'h1 && hood_unlock === 1'h1) clash <= 1'h1;
  end
endmodule

// ### tb/system_status_indicator_tb.sv
// bench for the status indicator: power-state rows, then security, hood,
// bus-error, intrusion and fault cases
// assumes ssi_top, ssi_panel_model and core/ssi_params.svh on the include path
`timescale 1ns/1ps
`include "ssi_params.svh"
module system_status_indicator_tb;
  localparam int T = 10;
  typedef struct {logic [2:0] ps; logic [7:0] src; logic ch, ph, fon, fhi, wk; int g;} ssi_row_s;
  logic aclk = '0, aresetn = '0, rtc_rstn = '0, cpu_hot = '0, psu_hot = '0, cover_open = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, wake_src = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cover_n;
  logic led_green, led_red, beep, wake_req, serial_dis, parallel_dis, usb_dis, diskette_dis;
  logic media_wr_en, media_boot_en, hood_lock, hood_unlock, fan_on, fan_high, irq, clash;
  int red_cnt, beep_cnt, error_cnt = 0, n_compared = 0, g, r0, b0;
  // green count over 8T: steady, blinking half the time, or dark
  ssi_row_s rows[8] = '{
    '{3'h0, 8'hFF, '0, '0, '1, '0, '0, 8*T},
    '{3'h1, 8'h20, '1, '0, '1, '1, '1, 4*T},
    '{3'h3, 8'h01, '0, '1, '1, '0, '1, 4*T},
    '{3'h3, 8'h00, '0, '0, '0, '0, '0, 4*T},
    '{3'h4, 8'hE0, '0, '0, '0, '0, '0, 0},
    '{3'h4, 8'h04, '0, '1, '1, '0, '1, 0},
    '{3'h5, 8'h10, '1, '0, '1, '1, '1, 0},
    '{3'h5, 8'hE0, '0, '0, '0, '0, '0, 0}};

  ssi_top #(.HALF_SEC_CYC(T)) u_ssi_top (.aclk, .aresetn, .rtc_rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cover_n,
    .wake_src, .cpu_hot, .psu_hot, .led_green, .led_red, .beep, .wake_req, .serial_dis,
    .parallel_dis, .usb_dis, .diskette_dis, .media_wr_en, .media_boot_en, .hood_lock,
    .hood_unlock, .fan_on, .fan_high, .irq);
  ssi_panel_model u_ssi_panel_model (.aclk, .cover_open, .led_red, .beep, .hood_lock,
    .hood_unlock, .cover_n, .red_cnt, .beep_cnt, .clash);

  always #2.5 aclk = ~aclk;

  // ************
  // helpers
  // ************
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(int n);
    if (n >= 64) begin
      error_cnt++;
      $display("wrong value handshake: expected an answer, seen none");
      report_and_stop();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] er = `SSI_RESP_OKAY);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      hang(n);
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] er = `SSI_RESP_OKAY,
                    logic [31:0] m = 32'hFFFFFFFF);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      hang(n);
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rresp", s_axi_rresp, er);
    chk("rdata", s_axi_rdata & m, exp);
    @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask
  task automatic cnt(ref logic s, input int n);
    g = 0;
    // sample first: the edge the task is entered at already shows the new level
    repeat (n) begin
      g += (s === 1'h1);
      @(posedge aclk);
    end
  endtask
  task automatic tend(string s);
    $display("test %s done", s);
  endtask

  // ************
  // sequence
  // ************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rtc_rstn <= 1'h1;
    @(posedge aclk);
    rd(`SSI_OFF_SECURITY, `SSI_SEC_RESET);
    rd(`SSI_OFF_HOOD, 32'h0);
    rd(`SSI_OFF_MASK, 32'h0);
    tend("reset values");
    foreach (rows[i]) begin
      wake_src <= 8'h00;
      wr(`SSI_OFF_CTRL, {29'h0, rows[i].ps});
      wake_src <= rows[i].src;
      cpu_hot <= rows[i].ch;
      psu_hot <= rows[i].ph;
      repeat (2) @(posedge aclk);
      cnt(led_green, 8*T);
      chk("green", g, rows[i].g);
      chk("fan_on", fan_on, rows[i].fon);
      chk("fan_high", fan_high, rows[i].fhi);
      chk("wake_req", wake_req, rows[i].wk);
    end
    wake_src <= 8'h00;
    rd(`SSI_OFF_WAKE, 32'h10, `SSI_RESP_OKAY, 32'hFF);
    wr(`SSI_OFF_MASK, 32'h2);
    @(posedge aclk);
    chk("irq", irq, 1'h1);
    wr(`SSI_OFF_STATUS, 32'h2);
    @(posedge aclk);
    chk("irq", irq, 1'h0);
    tend("power state rows");
    wr(`SSI_OFF_SECURITY, 32'h05);
    chk("security", {serial_dis, parallel_dis, usb_dis, diskette_dis, media_wr_en,
        media_boot_en}, 6'h28);
    wr(`SSI_OFF_SECURITY, 32'h3A);
    chk("security", {serial_dis, parallel_dis, usb_dis, diskette_dis, media_wr_en,
        media_boot_en}, 6'h17);
    for (int i = 1; i < 4; i++) begin
      wr(`SSI_OFF_HOOD, i);
      chk("hood", {hood_lock, hood_unlock}, (i == 3) ? 2'h0 : {i[0], i[1]});
    end
    chk("clash", clash, 1'h0);
    wr(8'h1C, 32'hFF, `SSI_RESP_SLVERR);
    rd(8'h1C, 32'h0, `SSI_RESP_SLVERR);
    tend("security hood bus");
    // cover opened and shut again while the system is held off
    aresetn <= 1'h0;
    cover_open <= 1'h1;
    repeat (4) @(posedge aclk);
    cover_open <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`SSI_OFF_STATUS, 32'h1, `SSI_RESP_OKAY, 32'h1);
    wr(`SSI_OFF_STATUS, 32'h1);
    rd(`SSI_OFF_STATUS, 32'h1, `SSI_RESP_OKAY, 32'h1);
    wr(`SSI_OFF_MASK, 32'h1);
    @(posedge aclk);
    chk("irq", irq, 1'h1);
    wr(`SSI_OFF_CTRL, 32'h8);
    wr(`SSI_OFF_STATUS, 32'h1);
    rd(`SSI_OFF_STATUS, 32'h0, `SSI_RESP_OKAY, 32'h1);
    chk("irq", irq, 1'h0);
    tend("intrusion");
    for (int c = 2; c <= 10; c++) begin
      rst();
      r0 = red_cnt;
      b0 = beep_cnt;
      wr(`SSI_OFF_FAULT, c);
      cnt(led_red, (2*c+3)*T);
      chk("red blinks", red_cnt - r0, c);
      chk("red on time", g, c*T);
      chk("beeps", beep_cnt - b0, (c < 10) ? c : 0);
      chk("green", led_green, 1'h0);
      cnt(led_red, T-2);
      chk("pause", g, 0);
      cnt(led_red, 2*T);
      chk("repeat", g, T);
    end
    tend("fault codes");
    rst();
    wr(`SSI_OFF_FAULT, 32'hB);
    rd(`SSI_OFF_FAULT, 32'h0, `SSI_RESP_OKAY, 32'h10);
    r0 = red_cnt;
    b0 = beep_cnt;
    wr(`SSI_OFF_FAULT, 32'h2);
    wr(`SSI_OFF_FAULT, 32'h7);
    rd(`SSI_OFF_FAULT, 32'h12, `SSI_RESP_OKAY, 32'h1F);
    repeat (64*T-30) @(posedge aclk);
    chk("red blinks", red_cnt - r0, 16);
    chk("beeps", beep_cnt - b0, 10);
    rd(`SSI_OFF_FAULT, 32'h500, `SSI_RESP_OKAY, 32'h700);
    rd(`SSI_OFF_STATUS, 32'h4, `SSI_RESP_OKAY, 32'h4);
    tend("beep limit");
    report_and_stop();
  end
endmodule
